//--- hdl/reset_sequencer.sv
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
// reset sequencing, prescaler, watchdog and interrupt latch for the core
module reset_sequencer #(
    parameter int unsigned long_count = rst_seq_pkg::long_cycles,
    parameter int unsigned irq_n = rst_seq_pkg::irq_count
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic power_on_reset_signal,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    input wire logic low_voltage_detector,
    input wire logic monitor_entry_reset,
    input wire logic illegal_opcode,
    input wire logic stop_instr,
    input wire logic stop_enable_opt,
    input wire logic short_stop_recovery,
    input wire logic opcode_fetch,
    input wire logic unmapped_addr,
    input wire logic monitor_mode,
    input wire logic break_state,
    input wire logic hv_on_reset_pin,
    input wire logic hv_on_irq_pin,
    input wire logic wake_event,
    input wire logic instr_done,
    input wire logic int_mask,
    input wire logic rti_done,
    input wire logic [irq_n-1:0] irq_req,
    input wire logic [irq_n-1:0] irq_en,
    output logic internal_reset_signal,
    output logic clock_gen_output,
    output logic internal_bus_clocks,
    output logic int_start,
    output logic [4:0] int_vector,
    output logic stack_regs
);
    localparam int unsigned long_lim = long_count - 1;
    localparam int unsigned pin_lim = rst_seq_pkg::pin_cycles - 1;
    localparam int unsigned rel_lim = rst_seq_pkg::release_cycles - 1;
    localparam int unsigned short_lim = rst_seq_pkg::short_cycles - 1;

    rst_seq_pkg::seq_state_t state_r, state_nxt;
    logic [12:0] presc_r, presc_nxt;
    logic [7:0] wdog_r;
    logic [7:0] cause_r, cause_nxt;
    logic [12:0] cnt_r, cnt_nxt;
    logic long_hold_r;
    logic [1:0] ctrl_r;
    logic [2:0] sync1_r, sync2_r;
    logic latched_r;
    logic [4:0] latch_idx_r;
    logic [31:0] prdata_r;
    logic pin_ext_r;

    // bus decode
    wire logic wr_en = psel & penable & pwrite;
    wire logic rd_en = psel & penable & ~pwrite;
    wire logic hit_cause = paddr == rst_seq_pkg::cause_addr;
    wire logic hit_istat = paddr == rst_seq_pkg::istat_addr;
    wire logic hit_ctrl = paddr == rst_seq_pkg::ctrl_addr;
    wire logic hit_service = paddr == rst_seq_pkg::service_addr;
    wire logic hit_vector = paddr == rst_seq_pkg::vector_addr;
    wire logic mapped = hit_cause | hit_istat | hit_ctrl | hit_service | hit_vector;
    wire logic service_wr = wr_en & hit_service;

    // async requests pass two flops before use
    wire logic wdog_sync = sync2_r[0];
    wire logic lvd_sync = sync2_r[1];
    wire logic pin_sync = sync2_r[2];
    // own drive masked, so the echo of our pin drive cannot stretch the hold phase
    wire logic pin_low_ext = ~reset_pin_in & ~reset_pin_oe;

    // watchdog can only be blocked by the high-voltage detect terms
    wire logic wdog_off = (monitor_mode & (hv_on_reset_pin | hv_on_irq_pin))
                        | (break_state & hv_on_reset_pin);
    wire logic presc_ovf = &presc_r;
    wire logic wdog_ovf = presc_ovf & (&wdog_r) & ~wdog_off;

    // internal reset sources, all equal and unarbitrated
    wire logic src_illegal_opcode_flag = illegal_opcode | (stop_instr & ~stop_enable_opt);
    wire logic src_illegal_address_flag = opcode_fetch & unmapped_addr;
    wire logic src_wdog = wdog_sync;
    wire logic src_lvd = lvd_sync;
    wire logic src_mod = monitor_entry_reset;
    wire logic in_reset = state_r == rst_seq_pkg::st_pin || state_r == rst_seq_pkg::st_hold;
    wire logic int_src = ~in_reset
                       & (src_illegal_opcode_flag | src_illegal_address_flag | src_wdog | src_lvd | src_mod);
    wire logic ext_src = ~in_reset & pin_sync & ~reset_pin_oe;

    wire logic [irq_n-1:0] pend = irq_req & irq_en;
    wire logic arb_any;
    wire logic [4:0] arb_idx;

    prio_arbiter #(
        .n(irq_n)
    ) u_arb (
        .req(pend),
        .any(arb_any),
        .idx(arb_idx)
    );

    // sequencer and counter next state
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r + 13'h0001;
        cause_nxt = cause_r;
        presc_nxt = presc_r + 13'h0001;
        if (service_wr) begin
            presc_nxt = presc_r & rst_seq_pkg::presc_service_mask;
        end
        case (state_r)
            rst_seq_pkg::st_run: begin
                if (int_src) begin
                    state_nxt = rst_seq_pkg::st_pin;
                    cnt_nxt = 13'h0000;
                    presc_nxt = rst_seq_pkg::presc_reset;
                    cause_nxt = {1'b0, 1'b0, src_wdog, src_illegal_opcode_flag, src_illegal_address_flag,
                                 src_mod, src_lvd, 1'b0};
                end else if (ext_src) begin
                    state_nxt = rst_seq_pkg::st_hold;
                    cnt_nxt = 13'h0000;
                    cause_nxt = 8'h00;
                    cause_nxt[rst_seq_pkg::cause_pin] = 1'b1;
                end else if (stop_instr & stop_enable_opt) begin
                    state_nxt = rst_seq_pkg::st_stop;
                    presc_nxt = rst_seq_pkg::presc_reset;
                end
            end
            rst_seq_pkg::st_pin: begin
                // long hold for power and low-voltage, short for the rest
                if ((long_hold_r && cnt_r == 13'(long_lim))
                        || (!long_hold_r && cnt_r == 13'(pin_lim))) begin
                    state_nxt = rst_seq_pkg::st_hold;
                    cnt_nxt = 13'h0000;
                end
            end
            rst_seq_pkg::st_hold: begin
                if (pin_sync) begin
                    cnt_nxt = 13'h0000; // pin still held low from outside
                end else if (cnt_r == 13'(rel_lim)
                        || (!long_hold_r && cnt_r == 13'(pin_lim))) begin
                    state_nxt = rst_seq_pkg::st_run;
                end
            end
            rst_seq_pkg::st_stop: begin
                if (int_src) begin
                    state_nxt = rst_seq_pkg::st_pin;
                    cnt_nxt = 13'h0000;
                    cause_nxt = {1'b0, 1'b0, src_wdog, src_illegal_opcode_flag, src_illegal_address_flag,
                                 src_mod, src_lvd, 1'b0};
                end else if (wake_event || pin_sync) begin
                    // recovery length picked at the exit moment
                    if (short_stop_recovery ? presc_r >= 13'(short_lim)
                            : presc_r >= 13'(long_lim)) begin
                        state_nxt = rst_seq_pkg::st_run;
                    end
                end else begin
                    presc_nxt = rst_seq_pkg::presc_reset; // counter idles until a wake
                end
            end
            default: begin
                state_nxt = rst_seq_pkg::st_run;
            end
        endcase
    end

    // synchronisers for watchdog, low voltage and pin requests
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= 3'h0;
            sync2_r <= 3'h0;
        end else begin
            sync1_r <= {pin_low_ext, low_voltage_detector, wdog_ovf};
            sync2_r <= sync1_r;
        end
    end

    // sequencer; presetn stands for the power-on pulse at the pin level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= rst_seq_pkg::st_pin;
            cnt_r <= 13'h0000;
            cause_r <= rst_seq_pkg::cause_reset;
            presc_r <= rst_seq_pkg::presc_reset;
            long_hold_r <= 1'b1;
        end else if (power_on_reset_signal) begin
            state_r <= rst_seq_pkg::st_pin;
            cnt_r <= 13'h0000;
            cause_r <= rst_seq_pkg::cause_reset;
            presc_r <= rst_seq_pkg::presc_reset;
            long_hold_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            cause_r <= cause_nxt;
            presc_r <= presc_nxt;
            // length picked on every entry to the pin phase, from stop too
            if (state_r != rst_seq_pkg::st_pin && state_nxt == rst_seq_pkg::st_pin) begin
                long_hold_r <= src_lvd;
            end else if (state_r == rst_seq_pkg::st_run && ext_src) begin
                long_hold_r <= 1'b1; // pin reset releases 64 cycles after the pin
            end
        end
    end

    // watchdog advanced by prescaler overflow, cleared by service writes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdog_r <= rst_seq_pkg::wdog_reset;
        end else if (service_wr || in_reset || wdog_off) begin
            wdog_r <= rst_seq_pkg::wdog_reset;
        end else if (presc_ovf) begin
            wdog_r <= wdog_r + 8'h01;
        end
    end

    // interrupt latch: once caught, held until the entry fires or a reset clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            latched_r <= 1'b0;
            latch_idx_r <= 5'h00;
        end else if (in_reset) begin
            latched_r <= 1'b0;
            latch_idx_r <= 5'h00;
        end else if (latched_r) begin
            if (int_start) begin
                latched_r <= 1'b0;
            end
        end else if ((instr_done || rti_done) && !int_mask && arb_any) begin
            latched_r <= 1'b1;
            latch_idx_r <= arb_idx;
        end
    end

    // entry fires the cycle after latching; core sets mask and stacks except high index
    assign int_start = latched_r & ~in_reset;
    assign stack_regs = int_start;
    assign int_vector = latch_idx_r;

    // control register: bit0 drops clock output, bit1 spare gate of bus clocks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= rst_seq_pkg::ctrl_reset;
        end else if (wr_en && hit_ctrl) begin
            ctrl_r <= pwdata[1:0];
        end
    end

    // read mux registered at the setup-phase edge
    wire logic [31:0] rd_val = hit_cause ? {24'h00_0000, cause_r}
                             : hit_istat ? {{(32 - irq_n){1'b0}}, pend}
                             : hit_ctrl ? {30'h0000_0000, ctrl_r}
                             : hit_vector ? {27'h000_0000, latch_idx_r}
                             : 32'h0000_0000;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= rd_val;
        end
    end

    // pin drive enable registered from the next state, so it follows the pin phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_ext_r <= 1'b1;
        end else begin
            pin_ext_r <= (state_r == rst_seq_pkg::st_run && int_src)
                       || (state_nxt == rst_seq_pkg::st_pin);
        end
    end

    // setup-phase capture gives zero-wait answers
    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe = pin_ext_r;
    assign internal_reset_signal = in_reset;
    assign clock_gen_output = ~ctrl_r[0];
    assign internal_bus_clocks = state_r == rst_seq_pkg::st_run && !ctrl_r[1];
endmodule
`default_nettype wire

//--- inc/rst_seq_pkg.sv
package rst_seq_pkg;
    localparam int unsigned presc_width = 13;
    localparam int unsigned wdog_width = 8;
    localparam int unsigned irq_count = 16;
    localparam int unsigned long_cycles = 4096;
    localparam int unsigned short_cycles = 32;
    localparam int unsigned release_cycles = 64;
    localparam int unsigned pin_cycles = 32;
    localparam logic [12:0] presc_reset = 13'h0000;
    localparam logic [12:0] presc_service_mask = 13'h000f; // keeps bits 3..0
    // register byte offsets on the bus
    localparam logic [11:0] cause_addr = 12'h000;
    localparam logic [11:0] istat_addr = 12'h004;
    localparam logic [11:0] ctrl_addr = 12'h008;
    localparam logic [11:0] service_addr = 12'h00c;
    localparam logic [11:0] vector_addr = 12'h010;
    // cause flag positions
    localparam int unsigned cause_por = 7;
    localparam int unsigned cause_pin = 6;
    localparam int unsigned cause_wdog = 5;
    localparam int unsigned cause_illegal_opcode_flag = 4;
    localparam int unsigned cause_illegal_address_flag = 3;
    localparam int unsigned cause_mod = 2;
    localparam int unsigned cause_lvd = 1;
    localparam logic [7:0] cause_reset = 8'h80;
    localparam logic [1:0] ctrl_reset = 2'h0;
    localparam logic [7:0] wdog_reset = 8'h00;
    typedef enum logic [3:0] {
        st_run = 4'b0001,
        st_pin = 4'b0010,
        st_hold = 4'b0100,
        st_stop = 4'b1000
    } seq_state_t;
endpackage

//--- hdl/prio_arbiter.sv
`timescale 1ns/100ps
`default_nettype none
// picks the lowest-numbered pending source; source 0 is highest priority and is reported as index 1
module prio_arbiter #(
    parameter int unsigned n = 16
) (
    input wire logic [n-1:0] req,
    output logic any,
    output logic [4:0] idx
);
    // scan from the lowest priority upward so the highest wins
    always_comb begin
        any = |req;
        idx = 5'h00;
        for (int i = n - 1; i >= 0; i--) begin
            if (req[i]) begin
                idx = 5'(i + 1);
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/rst_seq_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module rst_seq_checker #(
    parameter int unsigned long_count = 4096,
    parameter int unsigned irq_n = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic reset_pin_oe,
    input wire logic illegal_opcode,
    input wire logic opcode_fetch,
    input wire logic unmapped_addr,
    input wire logic instr_done,
    input wire logic int_mask,
    input wire logic [irq_n-1:0] irq_req,
    input wire logic [irq_n-1:0] irq_en,
    input wire logic internal_reset_signal,
    input wire logic internal_bus_clocks,
    input wire logic int_start,
    input wire logic [4:0] int_vector,
    input wire logic stack_regs
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [15:0] oe_n_r;
    logic [15:0] tail_n_r;
    // run lengths of pin drive and of the reset tail; too long for a repetition
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_n_r <= 16'h0000;
            tail_n_r <= 16'h0000;
        end else begin
            oe_n_r <= reset_pin_oe ? oe_n_r + 16'h0001 : 16'h0000;
            tail_n_r <= (internal_reset_signal && !reset_pin_oe) ? tail_n_r + 16'h0001 : 16'h0000;
        end
    end
    a_pin_in_reset: assert property (reset_pin_oe |-> internal_reset_signal)
        else $error("pin driven outside reset");
    a_pin_run_len: assert property ($fell(reset_pin_oe) |->
        oe_n_r == 16'h0020 || oe_n_r == long_count)
        else $error("pin drive length wrong");
    a_tail_run_len: assert property ($fell(internal_reset_signal) |->
        tail_n_r == 16'h0020 || tail_n_r == 16'h0040)
        else $error("reset tail length wrong");
    a_bus_clk_gated: assert property (internal_reset_signal |-> !internal_bus_clocks)
        else $error("bus clocks run in reset");
    a_illegal_opcode_flag_drives_pin: assert property (illegal_opcode && !internal_reset_signal |=>
        reset_pin_oe)
        else $error("illegal opcode did not reset");
    a_data_fetch_ok: assert property (unmapped_addr && !opcode_fetch
        && !internal_reset_signal |=> !reset_pin_oe)
        else $error("data fetch caused reset");
    a_irq_taken: assert property (instr_done && !int_mask && |(irq_req & irq_en)
        && !internal_reset_signal |-> ##[1:3] int_start)
        else $error("pending interrupt not taken");
    a_irq_masked: assert property (instr_done && int_mask |=>
        !int_start ##1 !int_start)
        else $error("masked interrupt taken");
    a_vec_enabled: assert property (int_start |->
        int_vector != 5'h00 && irq_en[int_vector - 5'h01])
        else $error("vector of disabled source");
    a_stack_entry: assert property (int_start |-> stack_regs)
        else $error("no stacking on entry");
    a_zero_wait: assert property (psel && penable |-> pready)
        else $error("bus not ready");
    a_unmapped_err: assert property (psel && penable
        && paddr > rst_seq_pkg::vector_addr |-> pslverr)
        else $error("unmapped access not refused");
    c_int: cover property (int_start);
    c_pin: cover property ($fell(reset_pin_oe));
    c_err: cover property (pslverr);
endmodule
bind reset_sequencer rst_seq_checker #(.long_count(long_count), .irq_n(irq_n)) rst_seq_checker_inst (
    .pclk, .presetn, .psel, .penable, .paddr, .pready, .pslverr, .reset_pin_oe,
    .illegal_opcode, .opcode_fetch, .unmapped_addr, .instr_done, .int_mask, .irq_req,
    .irq_en, .internal_reset_signal, .internal_bus_clocks, .int_start, .int_vector,
    .stack_regs
);
`default_nettype wire

//--- verification/core_model.sv
`timescale 1ns/100ps
`default_nettype none
// core stand-in: runs a service routine on each interrupt start, then returns
module core_model #(
    parameter int svc = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic int_start,
    input wire logic internal_reset_signal,
    input wire logic hold_mask,
    output logic int_mask,
    output logic rti_done
);
    logic in_isr_r;
    int n_r;
    // high index register is not in the stacked frame, routine saves it
    assign int_mask = in_isr_r | hold_mask;
    // mask set on entry, dropped with the return pulse; reset abandons the routine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_isr_r <= 1'b0;
            rti_done <= 1'b0;
            n_r <= 0;
        end else begin
            rti_done <= 1'b0;
            n_r <= n_r + 1;
            if (internal_reset_signal) begin
                in_isr_r <= 1'b0;
            end else if (int_start) begin
                in_isr_r <= 1'b1;
                n_r <= 0;
            end else if (in_isr_r && n_r == svc) begin
                in_isr_r <= 1'b0;
                rti_done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    localparam int lc = 80;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, hold = 1'b0, instr_done = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [5:0] src = 6'h00;
    logic [15:0] irq_req = 16'h0000, irq_en = 16'h0000;
    logic power_on_reset_signal = 1'b0, stop_enable_opt = 1'b0, short_stop_recovery = 1'b0;
    logic monitor_mode = 1'b0, break_state = 1'b0, hv_on_reset_pin = 1'b0;
    logic hv_on_irq_pin = 1'b0, wake_event = 1'b0;
    wire illegal_opcode = src[0];
    wire stop_instr = src[1];
    wire opcode_fetch = src[2];
    wire unmapped_addr = src[3];
    wire monitor_entry_reset = src[4];
    wire low_voltage_detector = src[5];
    wire [31:0] prdata;
    wire [4:0] int_vector;
    wire pready, pslverr, reset_pin_out, reset_pin_oe, internal_reset_signal, stack_regs;
    wire clock_gen_output, internal_bus_clocks, int_start, int_mask, rti_done, reset_pin_in;
    int bad_count = 0, cmp_count = 0, starts = 0;
    logic [31:0] rq[$], iq[$];
    logic [5:0] srcs[5] = '{6'h01, 6'h02, 6'h0c, 6'h10, 6'h20};
    logic [7:0] causes[5] = '{8'h10, 8'h10, 8'h08, 8'h04, 8'h02};
    // pull-up on the reset pin when nobody drives it
    assign reset_pin_in = reset_pin_oe ? reset_pin_out : 1'b1;
    always #2.5 pclk = ~pclk;
    reset_sequencer #(.long_count(lc)) reset_sequencer_inst (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .power_on_reset_signal,
        .reset_pin_in, .reset_pin_out, .reset_pin_oe, .low_voltage_detector,
        .monitor_entry_reset, .illegal_opcode, .stop_instr, .stop_enable_opt,
        .short_stop_recovery, .opcode_fetch, .unmapped_addr, .monitor_mode, .break_state,
        .hv_on_reset_pin, .hv_on_irq_pin, .wake_event, .instr_done, .int_mask, .rti_done,
        .irq_req, .irq_en, .internal_reset_signal, .clock_gen_output, .internal_bus_clocks,
        .int_start, .int_vector, .stack_regs);
    core_model core_model_inst (.pclk, .presetn, .int_start, .internal_reset_signal,
        .hold_mask(hold), .int_mask, .rti_done);
    task automatic end_sim();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic give_up();
        bad_count++;
        end_sim();
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) give_up();
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rq.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // counts cycles of pin drive and of internal reset until reset ends
    task automatic meas(input int eo, input int ei);
        int o, i, k;
        o = 0;
        i = 0;
        for (k = 0; k < 3000; k++) begin
            @(posedge pclk);
            if (reset_pin_oe === 1'b1) o++;
            if (internal_reset_signal === 1'b1) i++;
            else if (i > 0) break;
        end
        if (k >= 3000) give_up();
        check(32'(o), 32'(eo));
        check(32'(i), 32'(ei));
    endtask
    task automatic wait_int();
        int k;
        for (k = 0; k < 200 && int_start !== 1'b1; k++) @(posedge pclk);
        if (k >= 200) give_up();
    endtask
    function automatic logic [31:0] lowest(input logic [15:0] x);
        for (int b = 0; b < 16; b++) if (x[b]) return 32'(b + 1);
        return 32'h0000_0000;
    endfunction
    // results are compared against the oldest expectation as they appear
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            check(prdata, rq.pop_front());
        end
        if (int_start === 1'b1) begin
            starts++;
            check(32'(int_vector), iq.pop_front());
        end
    end
    initial begin
        logic [15:0] r;
        int k;
        void'($urandom(32'h782f8ae0));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        meas(lc, lc + 64);
        rd(rst_seq_pkg::cause_addr, 32'h0000_0080);
        $display("test power_on done");
        apb(1'b1, rst_seq_pkg::ctrl_addr, 32'h0000_0003);
        // the write lands at the access edge; look one cycle later
        @(posedge pclk);
        check(32'({clock_gen_output, internal_bus_clocks}), 32'h0000_0000);
        rd(rst_seq_pkg::ctrl_addr, 32'h0000_0003);
        apb(1'b1, rst_seq_pkg::ctrl_addr, 32'h0000_0000);
        @(posedge pclk);
        check(32'({clock_gen_output, internal_bus_clocks}), 32'h0000_0003);
        apb(1'b1, rst_seq_pkg::service_addr, $urandom);
        rd(12'h0f0, 32'h0000_0000);
        $display("test registers done");
        src <= 6'h08;
        @(posedge pclk);
        src <= 6'h00;
        repeat (4) @(posedge pclk);
        check(32'(reset_pin_oe), 32'h0000_0000);
        // each internal reset source except the watchdog in turn, cause register replaced each time
        for (int s = 0; s < 5; s++) begin
            @(posedge pclk);
            src <= srcs[s];
            @(posedge pclk);
            src <= 6'h00;
            meas(s == 4 ? lc : 32, s == 4 ? lc + 64 : 64);
            rd(rst_seq_pkg::cause_addr, 32'(causes[s]));
        end
        $display("test reset sources done");
        // legal stop, woken at once: bus clocks stay off for the short recovery
        stop_enable_opt <= 1'b1;
        short_stop_recovery <= 1'b1;
        @(posedge pclk);
        src <= 6'h02;
        @(posedge pclk);
        src <= 6'h00;
        wake_event <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (internal_bus_clocks !== 1'b1 && k < 200);
        if (internal_bus_clocks !== 1'b1) give_up();
        wake_event <= 1'b0;
        stop_enable_opt <= 1'b0;
        short_stop_recovery <= 1'b0;
        check(32'(k - 1), 32'(rst_seq_pkg::short_cycles));
        $display("test stop done");
        r = 16'($urandom) | 16'hc000;
        @(posedge pclk);
        irq_en <= 16'hffff;
        irq_req <= r;
        hold <= 1'b1;
        @(posedge pclk);
        instr_done <= 1'b1;
        @(posedge pclk);
        instr_done <= 1'b0;
        repeat (4) @(posedge pclk);
        check(32'(starts), 32'h0000_0000);
        hold <= 1'b0;
        iq.push_back(lowest(r));
        @(posedge pclk);
        instr_done <= 1'b1;
        @(posedge pclk);
        instr_done <= 1'b0;
        wait_int();
        r = r & ~(16'h0001 << (lowest(r) - 1));
        irq_req <= r;
        iq.push_back(lowest(r));
        @(posedge pclk);
        wait_int();
        irq_req <= 16'h0000;
        repeat (30) @(posedge pclk);
        check(32'(starts), 32'h0000_0002);
        check(32'(iq.size()), 32'h0000_0000);
        $display("test interrupts done");
        end_sim();
    end
endmodule
`default_nettype wire
